// ===== design/host_port_pkg.sv
// Constants and types shared by the host processor port and its lane helper.
// Assumes a single host bus clock that also times the internal bus side.
package host_port_pkg;

  // Host address field and its decode window
  localparam int ADDR_W = 18;
  localparam logic [17:0] DECODE_MASK_DEF = 18'h3_0000;
  localparam logic [17:0] DECODE_BASE_DEF = 18'h0_0000;

  // Transfer size codes from the host
  localparam logic [1:0] SIZE_WORD = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;

  // Burst shape and lane layout
  localparam int BURST_BEATS_DEF = 4;
  localparam int LANE_BITS = 8;
  localparam int DATA_W_DEF = 32;

  // Parity sense: 1 gives odd parity per lane
  localparam logic ODD_PARITY_DEF = 1'b1;

  // Idle level of the active-low answer strobes
  localparam logic STROBE_IDLE = 1'b1;

  // Transaction states, Gray ordered along the usual path
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_REQ = 2'h1,
    ST_RESP = 2'h3
  } port_state_t;

  // Kind of answer given to the host
  typedef enum logic [1:0] {
    ANS_ACK = 2'h0,
    ANS_ERR = 2'h1,
    ANS_RETRY = 2'h2
  } answer_t;

endpackage : host_port_pkg

// ===== design/byte_lane_unit.sv
// Per-lane parity generation and byte enables for the host port.
// Assumes data lanes are DATA_W/8 bytes, lane k holding bits 8k+7:8k.
`timescale 1ns/1ps
`default_nettype none
module byte_lane_unit #(
  parameter int DATA_W = host_port_pkg::DATA_W_DEF,
  parameter logic ODD_PARITY = host_port_pkg::ODD_PARITY_DEF
) (
  // Data and transfer shape
  input wire logic [DATA_W-1:0] i_data,
  input wire logic [1:0] i_size,
  input wire logic [1:0] i_offset,
  // Lane results
  output logic [DATA_W/8-1:0] o_parity,
  output logic [DATA_W/8-1:0] o_be
);
  import host_port_pkg::*;

  localparam int NL = DATA_W / LANE_BITS;
  localparam logic [1:0] LMASK = 2'(NL - 1);

  // One parity bit and one enable per lane
  genvar k;
  generate
    for (k = 0; k < NL; k++)
    begin : g_lane
      localparam logic [1:0] LK = 2'(k);
      assign o_parity[k] = (^i_data[k*LANE_BITS +: LANE_BITS]) ^ ODD_PARITY;
      always_comb
      begin
        case (i_size)
          SIZE_BYTE: o_be[k] = (LK & LMASK) == (i_offset & LMASK);
          SIZE_HALF: o_be[k] = (LK & LMASK & 2'h2) == (i_offset & LMASK & 2'h2);
          default: o_be[k] = 1'b1;
        endcase
      end
    end
  endgenerate

endmodule : byte_lane_unit
`default_nettype wire

// ===== design/host_processor_port.sv
// Host processor bus port: slave of an external bus master, master of the
// internal system bus. Assumes host signals are synchronous to i_clk.
//
// Behaviour
// - Decode transfers from the 18 address bits
// - Dropped continuation ends burst, no more beats
// - Size code 01 byte, 10 half, 00 word
// - Acknowledge low on write taken or read data
// - Error acknowledge low on internal bus error
// - Retry asks host to release and reissue
// - All host signals timed on rising clock
// - Host clock selectable as internal bus clock
// - Data width configurable as 8, 16, 32
// - Port drives data only on reads
// - One parity bit per byte lane
`timescale 1ns/1ps
`default_nettype none
module host_processor_port #(
  parameter int DATA_W = host_port_pkg::DATA_W_DEF,
  parameter int BURST_BEATS = host_port_pkg::BURST_BEATS_DEF,
  parameter logic [17:0] DECODE_MASK = host_port_pkg::DECODE_MASK_DEF,
  parameter logic [17:0] DECODE_BASE = host_port_pkg::DECODE_BASE_DEF,
  parameter logic ODD_PARITY = host_port_pkg::ODD_PARITY_DEF
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Host request
  input wire logic i_transfer_start_n,
  input wire logic i_read_not_write,
  input wire logic [host_port_pkg::ADDR_W-1:0] i_host_address_in,
  input wire logic i_burst_indicator_n,
  input wire logic i_burst_continue_request,
  input wire logic [1:0] i_transfer_size_code,
  // Host data and parity pins
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe_n,
  input wire logic [DATA_W/8-1:0] i_byte_lane_parity,
  output logic [DATA_W/8-1:0] o_byte_lane_parity,
  output logic o_parity_oe_n,
  // Host answers
  output logic o_transfer_acknowledge_n,
  output logic o_transfer_error_ack_n,
  output logic o_bus_retry_request_n,
  // Internal bus clock source
  input wire logic i_sys_clk_sel_host,
  output logic o_sys_clk_sel_host,
  // Internal system bus
  output logic o_sys_req,
  output logic o_sys_write,
  output logic [host_port_pkg::ADDR_W-1:0] o_sys_addr,
  output logic [DATA_W-1:0] o_sys_wdata,
  output logic [DATA_W/8-1:0] o_sys_be,
  input wire logic i_sys_ready,
  input wire logic i_sys_error,
  input wire logic i_sys_retry,
  input wire logic [DATA_W-1:0] i_sys_rdata
);
  import host_port_pkg::*;

  localparam int NL = DATA_W / LANE_BITS;
  localparam logic [ADDR_W-1:0] BEAT_STEP = ADDR_W'(NL);
  localparam logic [7:0] LAST_BEAT = 8'(BURST_BEATS - 1);

  port_state_t state_r;
  answer_t answer_r;
  logic rd_r;
  logic burst_r;
  logic [1:0] size_r;
  logic [7:0] beat_r;
  logic [ADDR_W-1:0] addr_r;
  logic hit;
  logic start;
  logic sys_done;
  logic more_beats;
  logic par_bad;
  logic [NL-1:0] in_par;
  logic [NL-1:0] in_be;
  logic [NL-1:0] rd_par;

  // Lane helpers for incoming host data and outgoing read data
  byte_lane_unit #(.DATA_W(DATA_W), .ODD_PARITY(ODD_PARITY)) u_in_lanes (
    .i_data(i_data),
    .i_size(i_transfer_size_code),
    .i_offset(i_host_address_in[1:0]),
    .o_parity(in_par),
    .o_be(in_be)
  );
  byte_lane_unit #(.DATA_W(DATA_W), .ODD_PARITY(ODD_PARITY)) u_rd_lanes (
    .i_data(i_sys_rdata),
    .i_size(size_r),
    .i_offset(addr_r[1:0]),
    .o_parity(rd_par),
    .o_be()
  );

  // Request decode and write parity check
  assign hit = (i_host_address_in & DECODE_MASK) == DECODE_BASE;
  assign start = !i_transfer_start_n && hit;
  assign par_bad = !i_read_not_write && (((i_byte_lane_parity ^ in_par) & in_be) != '0);
  assign sys_done = i_sys_ready || i_sys_error || i_sys_retry;
  assign more_beats = burst_r && (beat_r != LAST_BEAT) && (answer_r == ANS_ACK);

  // Transaction sequencing
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
          if (start)
            state_r <= par_bad ? ST_RESP : ST_REQ;
        ST_REQ:
          if (sys_done)
            state_r <= ST_RESP;
        ST_RESP:
          if (more_beats && i_burst_continue_request)
            state_r <= ST_REQ;
          else
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Transfer attributes, beat count and address
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rd_r <= 1'b0;
      burst_r <= 1'b0;
      size_r <= SIZE_WORD;
      beat_r <= '0;
      addr_r <= '0;
    end
    else if (state_r == ST_IDLE && start)
    begin
      rd_r <= i_read_not_write;
      burst_r <= !i_burst_indicator_n;
      size_r <= i_burst_indicator_n ? i_transfer_size_code : SIZE_WORD;
      beat_r <= '0;
      addr_r <= i_host_address_in;
    end
    else if (state_r == ST_RESP && more_beats && i_burst_continue_request)
    begin
      beat_r <= beat_r + 8'h01;
      addr_r <= addr_r + BEAT_STEP;
    end
  end

  // Internal bus request, held until the internal bus answers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_sys_req <= 1'b0;
      o_sys_write <= 1'b0;
      o_sys_addr <= '0;
      o_sys_wdata <= '0;
      o_sys_be <= '0;
    end
    else if (state_r == ST_IDLE && start && !par_bad)
    begin
      o_sys_req <= 1'b1;
      o_sys_write <= !i_read_not_write;
      o_sys_addr <= i_host_address_in;
      o_sys_wdata <= i_data;
      o_sys_be <= i_burst_indicator_n ? in_be : '1;
    end
    else if (state_r == ST_RESP && more_beats && i_burst_continue_request)
    begin
      o_sys_req <= 1'b1;
      o_sys_addr <= addr_r + BEAT_STEP;
      o_sys_wdata <= i_data;
      o_sys_be <= '1;
    end
    else if (state_r == ST_REQ && sys_done)
      o_sys_req <= 1'b0;
  end

  // Answer selection: error beats retry beats acknowledge
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      answer_r <= ANS_ACK;
    else if (state_r == ST_IDLE && start)
      answer_r <= par_bad ? ANS_ERR : ANS_ACK;
    else if (state_r == ST_REQ && sys_done)
    begin
      if (i_sys_error)
        answer_r <= ANS_ERR;
      else if (i_sys_retry)
        answer_r <= ANS_RETRY;
      else
        answer_r <= ANS_ACK;
    end
  end

  // Answer strobes, low for exactly one clock per beat
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_transfer_acknowledge_n <= STROBE_IDLE;
      o_transfer_error_ack_n <= STROBE_IDLE;
      o_bus_retry_request_n <= STROBE_IDLE;
    end
    else
    begin
      o_transfer_acknowledge_n <= !(state_r == ST_REQ && i_sys_ready && !i_sys_error && !i_sys_retry);
      o_transfer_error_ack_n <= !((state_r == ST_REQ && i_sys_error)
                                 || (state_r == ST_IDLE && start && par_bad));
      o_bus_retry_request_n <= !(state_r == ST_REQ && i_sys_retry && !i_sys_error);
    end
  end

  // Read data and parity, driven only in the acknowledge cycle of a read
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_data <= '0;
      o_byte_lane_parity <= '0;
      o_data_oe_n <= 1'b1;
      o_parity_oe_n <= 1'b1;
    end
    else
    begin
      if (state_r == ST_REQ && i_sys_ready && rd_r)
      begin
        o_data <= i_sys_rdata;
        o_byte_lane_parity <= rd_par;
      end
      o_data_oe_n <= !(state_r == ST_REQ && rd_r && i_sys_ready && !i_sys_error && !i_sys_retry);
      o_parity_oe_n <= !(state_r == ST_REQ && rd_r && i_sys_ready && !i_sys_error && !i_sys_retry);
    end
  end

  // Internal bus clock source select, passed on as a registered level
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_sys_clk_sel_host <= 1'b0;
    else
      o_sys_clk_sel_host <= i_sys_clk_sel_host;
  end

  // Checks on the host-facing and internal bus behaviour
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_ack_one_cycle: assert property (!o_transfer_acknowledge_n |=> o_transfer_acknowledge_n)
    else $error("acknowledge held longer than one clock");
  a_ack_not_error: assert property (!(!o_transfer_acknowledge_n && !o_transfer_error_ack_n))
    else $error("acknowledge and error acknowledge together");
  a_ack_on_ready: assert property (state_r == ST_REQ && i_sys_ready && !i_sys_error && !i_sys_retry
    |=> !o_transfer_acknowledge_n)
    else $error("missing acknowledge after internal ready");
  a_error_on_fault: assert property (state_r == ST_REQ && i_sys_error |=> !o_transfer_error_ack_n ##1 o_transfer_error_ack_n)
    else $error("error acknowledge not one clock after bus error");
  a_retry_on_req: assert property (state_r == ST_REQ && i_sys_retry && !i_sys_error
    |=> !o_bus_retry_request_n && o_transfer_acknowledge_n)
    else $error("retry not signalled");
  a_miss_quiet: assert property (state_r == ST_IDLE && !hit |=> o_transfer_acknowledge_n && o_transfer_error_ack_n
    && o_bus_retry_request_n && !o_sys_req)
    else $error("undecoded address answered");
  a_abort_burst: assert property (state_r == ST_RESP && !i_burst_continue_request |=> state_r == ST_IDLE && !o_sys_req)
    else $error("burst continued without continuation request");
  a_read_drive: assert property (!o_data_oe_n |-> rd_r && !o_transfer_acknowledge_n)
    else $error("data driven outside a read acknowledge");
  a_byte_enable: assert property (state_r == ST_IDLE && start && !par_bad && i_burst_indicator_n
    && i_transfer_size_code == SIZE_BYTE |=> $onehot(o_sys_be))
    else $error("byte transfer enables not one lane");
  // The select register is cleared by reset, so skip the edge that follows a reset cycle
  a_clk_select: assert property (!$past(i_rst) |-> o_sys_clk_sel_host == $past(i_sys_clk_sel_host))
    else $error("clock source select not passed on");
  a_parity_with_read: assert property (!o_parity_oe_n |-> rd_r && !o_transfer_acknowledge_n)
    else $error("parity driven outside a read acknowledge");
  a_retry_alone: assert property (!o_bus_retry_request_n |-> o_transfer_acknowledge_n && o_transfer_error_ack_n)
    else $error("retry given together with another answer");
  a_error_one_cycle: assert property (!o_transfer_error_ack_n |=> o_transfer_error_ack_n)
    else $error("error acknowledge held longer than one clock");
  a_retry_one_cycle: assert property (!o_bus_retry_request_n |=> o_bus_retry_request_n)
    else $error("retry held longer than one clock");
  a_burst_next_addr: assert property (state_r == ST_RESP && more_beats && i_burst_continue_request
    |=> o_sys_req && o_sys_addr == $past(addr_r) + BEAT_STEP)
    else $error("continued burst beat not requested at next address");

  // Main scenarios that the bench is expected to reach
  c_single_read: cover property (state_r == ST_IDLE && start && i_read_not_write ##[1:20] !o_transfer_acknowledge_n);
  c_burst_full: cover property (burst_r && beat_r == LAST_BEAT && !o_transfer_acknowledge_n);
  c_burst_abort: cover property (state_r == ST_RESP && more_beats && !i_burst_continue_request);
  c_retry: cover property (!o_bus_retry_request_n);

endmodule : host_processor_port
`default_nettype wire

// ===== sim/host_master_model.sv
// Host bus master model: drives the port's request pins, counts answers.
// Assumes answer strobes are registered and read on rising edges.
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
  // Clock
  input wire logic i_clk,
  // Request pins
  output logic o_start_n,
  output logic o_rnw,
  output logic [17:0] o_addr,
  output logic o_burst_n,
  output logic o_cont,
  output logic [1:0] o_size,
  output logic [31:0] o_data,
  output logic [3:0] o_par,
  // Answers
  input wire logic i_ack_n,
  input wire logic i_tea_n,
  input wire logic i_rtry_n,
  input wire logic [31:0] i_rdata
);
  // Idle pins
  initial
  begin
    o_start_n = 1'b1;
    o_rnw = 1'b1;
    o_addr = 18'h0_0000;
    o_burst_n = 1'b1;
    o_cont = 1'b0;
    o_size = 2'h0;
    o_data = 32'h0000_0000;
    o_par = 4'h0;
  end

  // Odd parity, one bit per byte lane
  function automatic logic [3:0] odd_par(input logic [31:0] d);
    for (int k = 0; k < 4; k++)
      odd_par[k] = ~^d[8*k+:8];
  endfunction : odd_par

  // One transaction, then a watch for stray answers; ans 3 means none came
  task automatic xfer(input logic rw, input logic [17:0] a, input logic [1:0] sz, input logic bn,
                      input int beats, input logic [31:0] wd, input logic bad,
                      output logic [1:0] ans, output int nack, output logic [31:0] rd);
    ans = 2'h3;
    nack = 0;
    rd = 32'h0000_0000;
    @(posedge i_clk);
    o_start_n <= 1'b0;
    o_rnw <= rw;
    o_addr <= a;
    o_size <= sz;
    o_burst_n <= bn;
    o_cont <= beats > 1;
    o_data <= rw ? ~wd : wd;
    o_par <= odd_par(wd) ^ {3'b000, bad};
    @(posedge i_clk);
    o_start_n <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge i_clk);
      if (i_ack_n === 1'b0)
      begin
        nack++;
        rd = i_rdata;
        o_cont <= nack + 1 < beats;
        ans = (ans == 2'h3) ? 2'h0 : ans;
      end
      if (i_tea_n === 1'b0)
        ans = 2'h1;
      if (i_rtry_n === 1'b0)
        ans = 2'h2;
    end
    o_cont <= 1'b0;
    o_data <= ~wd;
  endtask : xfer
endmodule : host_master_model
`default_nettype wire

// ===== sim/test_host_processor_port.sv
// Table-driven bench for the host processor port.
// Assumes the internal bus answers at once unless mode says otherwise.
`timescale 1ns/1ps
`default_nettype none
module test_host_processor_port;
  import host_port_pkg::*;
  typedef struct {logic rw; logic [17:0] a; logic [1:0] sz; logic bn; int beats;
                  logic [1:0] md; logic [1:0] ans; int nack; logic [3:0] be;} row_t;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sel = 1'b0;
  logic [1:0] mode = 2'h0;
  logic start_n, rnw, burst_n, cont, d_oe_n, p_oe_n, ack_n, tea_n, rtry_n, sel_q, req, wr, cap_wr;
  logic [17:0] addr, s_addr, cap_addr, last;
  logic [1:0] size, ans;
  logic [31:0] h_data, d_out, wire_d, s_wd, cap_wd, rd, wd;
  logic [3:0] h_par, p_out, wire_p, s_be, cap_be, cap_rp;
  int error_cnt = 0;
  int n_checks = 0;
  int reqs = 0;
  int nack;
  row_t rows [9] = '{
    '{1'b0, 18'h0_0010, SIZE_WORD, 1'b1, 1, 2'h0, 2'h0, 1, 4'hF},
    '{1'b0, 18'h0_0011, SIZE_BYTE, 1'b1, 1, 2'h0, 2'h0, 1, 4'h2},
    '{1'b0, 18'h0_0012, SIZE_HALF, 1'b1, 1, 2'h0, 2'h0, 1, 4'hC},
    '{1'b1, 18'h0_0020, SIZE_WORD, 1'b1, 1, 2'h0, 2'h0, 1, 4'hF},
    '{1'b0, 18'h0_0030, SIZE_WORD, 1'b1, 1, 2'h1, 2'h1, 0, 4'hF},
    '{1'b1, 18'h0_0034, SIZE_WORD, 1'b1, 1, 2'h2, 2'h2, 0, 4'hF},
    '{1'b1, 18'h0_0040, SIZE_WORD, 1'b0, 4, 2'h0, 2'h0, 4, 4'hF},
    '{1'b0, 18'h0_0050, SIZE_WORD, 1'b0, 2, 2'h0, 2'h0, 2, 4'hF},
    '{1'b1, 18'h1_0000, SIZE_WORD, 1'b1, 1, 2'h0, 2'h3, 0, 4'hF}};

  always #2.5 i_clk = ~i_clk;

  // Shared pin levels, internal bus answering at once
  assign wire_d = d_oe_n ? h_data : d_out;
  assign wire_p = p_oe_n ? h_par : p_out;
  wire ready = req & (mode == 2'h0);
  wire fault = req & (mode == 2'h1);
  wire again = req & (mode == 2'h2);

  host_master_model host_u (.i_clk(i_clk), .o_start_n(start_n), .o_rnw(rnw), .o_addr(addr),
    .o_burst_n(burst_n), .o_cont(cont), .o_size(size), .o_data(h_data), .o_par(h_par),
    .i_ack_n(ack_n), .i_tea_n(tea_n), .i_rtry_n(rtry_n), .i_rdata(wire_d));

  host_processor_port dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_transfer_start_n(start_n),
    .i_read_not_write(rnw), .i_host_address_in(addr), .i_burst_indicator_n(burst_n),
    .i_burst_continue_request(cont), .i_transfer_size_code(size), .i_data(wire_d), .o_data(d_out),
    .o_data_oe_n(d_oe_n), .i_byte_lane_parity(wire_p), .o_byte_lane_parity(p_out),
    .o_parity_oe_n(p_oe_n), .o_transfer_acknowledge_n(ack_n), .o_transfer_error_ack_n(tea_n),
    .o_bus_retry_request_n(rtry_n), .i_sys_clk_sel_host(sel), .o_sys_clk_sel_host(sel_q),
    .o_sys_req(req), .o_sys_write(wr), .o_sys_addr(s_addr), .o_sys_wdata(s_wd), .o_sys_be(s_be),
    .i_sys_ready(ready), .i_sys_error(fault), .i_sys_retry(again),
    .i_sys_rdata({s_addr[15:0], ~s_addr[15:0]}));

  // Record internal requests and read parity
  always @(posedge i_clk)
  begin
    if (req === 1'b1)
    begin
      cap_addr <= s_addr;
      cap_be <= s_be;
      cap_wd <= s_wd;
      cap_wr <= wr;
      reqs += (mode != 2'h3);
    end
    if (ack_n === 1'b0)
      cap_rp <= wire_p;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask : chk_flag

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    chk_flag(ack_n & tea_n & rtry_n & d_oe_n & p_oe_n & ~req, 1'b1);
    foreach (rows[i])
    begin
      mode <= rows[i].md;
      reqs = 0;
      wd = {rows[i].a[15:0], rows[i].a[15:0]};
      host_u.xfer(rows[i].rw, rows[i].a, rows[i].sz, rows[i].bn, rows[i].beats, wd, 1'b0, ans, nack, rd);
      last = rows[i].a + 18'(4 * (rows[i].beats - 1));
      chk_val(32'(ans), 32'(rows[i].ans));
      chk_val(32'(nack), 32'(rows[i].nack));
      chk_val(32'(reqs), 32'(rows[i].ans == 2'h3 ? 0 : (rows[i].ans == 2'h0 ? rows[i].beats : 1)));
      if (reqs > 0)
        chk_val({13'h0, cap_addr, cap_wr}, {13'h0, last, ~rows[i].rw});
      if (reqs > 0 && !rows[i].rw)
        chk_val(32'(cap_be), 32'(rows[i].be));
      if (reqs > 0 && !rows[i].rw && rows[i].sz == SIZE_WORD)
        chk_val(cap_wd, wd);
      if (rows[i].rw && rows[i].ans == 2'h0)
        chk_val({rd[31:4], cap_rp}, {last[15:0], ~last[15:4], host_u.odd_par(rd)});
      if (ans == 2'h3 && rows[i].ans != 2'h3)
        wrap_up();
      $display("test %0d done", i);
    end
    // Bad write parity: error answer, no internal request
    mode <= 2'h0;
    reqs = 0;
    host_u.xfer(1'b0, 18'h0_0070, SIZE_WORD, 1'b1, 1, 32'h1234_5678, 1'b1, ans, nack, rd);
    chk_val({30'h0, ans} + 32'(reqs), 32'h1);
    $display("test parity done");
    // Internal clock source follows one cycle later
    sel <= 1'b1;
    @(posedge i_clk);
    chk_flag(sel_q, 1'b0);
    @(posedge i_clk);
    chk_flag(sel_q, 1'b1);
    $display("test clock select done");
    // Reset while the internal bus stalls, then recover
    mode <= 2'h3;
    host_u.xfer(1'b1, 18'h0_0060, SIZE_WORD, 1'b1, 1, 32'h0, 1'b0, ans, nack, rd);
    chk_val(32'(ans), 32'h3);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    mode <= 2'h0;
    chk_flag(ack_n & tea_n & rtry_n & d_oe_n & p_oe_n & ~req, 1'b1);
    host_u.xfer(1'b1, 18'h0_0064, SIZE_WORD, 1'b1, 1, 32'h0, 1'b0, ans, nack, rd);
    chk_val(rd, 32'h0064_FF9B);
    $display("test reset done");
    wrap_up();
  end
endmodule : test_host_processor_port
`default_nettype wire
